// File: bcdc_host.sv
// Host microcontroller model driving the serial register link
`timescale 1ns/1ps
`default_nettype none
module bcdc_host
	import bcdc_pkg::*;
(
	input  wire logic CLOCK,
	output var  logic SCLK,
	output var  logic CS_N,
	output var  logic MOSI,
	input  wire logic MISO
);
	// ==========================================================
	// Frame engine
	initial begin
		SCLK = 1'b0;
		CS_N = 1'b1;
		MOSI = 1'b0;
	end
	task automatic idle(input int n);
		repeat (n) @(posedge CLOCK);
	endtask
	// Short frames are sent only where the bench wants a refusal
	task automatic frame(input int nbits, input logic [15:0] word, output logic [7:0] rdata);
		rdata = 8'h00;
		CS_N <= 1'b0;
		idle(8);
		for (int i = 0; i < nbits; i++) begin
			MOSI <= word[15-i];
			idle(4);
			if (i >= 8) rdata[15-i] = MISO;
			SCLK <= 1'b1;
			idle(8);
			SCLK <= 1'b0;
			idle(4);
		end
		CS_N <= 1'b1;
		// Released data line shows the inverse, so no stale bit passes for data
		MOSI <= ~MOSI;
		idle(10);
	endtask
	task automatic wr(input logic [6:0] addr, input logic [7:0] data);
		logic [7:0] d;
		logic [7:0] unused;
		d = data;
		if (addr == ADR_DITH_EN) d[6] = 1'b0;
		if (addr == ADR_FUNC_CTRL) d = d & 8'h4F;
		if ((addr == ADR_ILIM_OUT1 || addr == ADR_ILIM_OUT2) && d > 8'h80) d = 8'h80;
		frame(16, {addr, 1'b0, d}, unused);
	endtask
	task automatic rd(input logic [6:0] addr, output logic [7:0] data);
		frame(16, {addr, 1'b1, 8'h00}, data);
	endtask
endmodule
`default_nettype wire

// File: bcdc_pkg.sv
// Register map, field layout, reset values and timing of the boost configuration block
package bcdc_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [6:0] ADR_FUNC_CTRL  = 7'h00;
	localparam logic [6:0] ADR_ILIM_OUT1  = 7'h07;
	localparam logic [6:0] ADR_ILIM_OUT2  = 7'h08;
	localparam logic [6:0] ADR_SCEN_OUT1  = 7'h0B;
	localparam logic [6:0] ADR_SCEN_OUT2  = 7'h0C;
	localparam logic [6:0] ADR_DITH_EN    = 7'h1C;
	localparam logic [6:0] ADR_RAMP_OUT2  = 7'h20;
	localparam logic [6:0] ADR_DEAD_BAND  = 7'h30;
	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_FUNC_CTRL  = 8'h00;
	localparam logic [7:0] RST_ILIM       = 8'h00;
	localparam logic [7:0] RST_SCEN       = 8'h00;
	localparam logic [7:0] RST_DITH_EN    = 8'h00;
	localparam logic [7:0] RST_RAMP_OUT2  = 8'h00;
	localparam logic [3:0] DB_INTERNAL    = 4'h9;
	localparam logic [1:0] RST_DEAD_BAND  = 2'h0;
	// ==========================================================
	// Field positions
	localparam int FC_CFG_DONE  = 0;
	localparam int FC_OUT1_EN   = 1;
	localparam int FC_OUT2_EN   = 2;
	localparam int FC_SEL_TMR   = 3;
	localparam int FC_VBAT_MEAS = 6;
	localparam int DE_CH1_ON    = 0;
	localparam int DE_CH1_RAND  = 1;
	localparam int DE_CH2_ON    = 2;
	localparam int DE_CH2_RAND  = 3;
	localparam int DE_RST_VBAT  = 4;
	localparam int DE_RST_TEMP  = 5;
	localparam int SC_WIDTH_LSB = 6;
	localparam int SC_SCEN_LSB  = 4;
	localparam int RU_DISABLE   = 5;
	localparam int RU_TIME_LSB  = 2;
	localparam int DB_LSB       = 4;
	// ==========================================================
	// Timing: clock 200 MHz, start-up interval and ramp base step
	localparam int CLK_MHZ          = 200;
	localparam int STARTUP_US       = 1000;
	localparam int STARTUP_CYC      = STARTUP_US * CLK_MHZ;
	localparam int STEP_BASE_US     = 40;
	localparam int STEP_BASE_CYC    = STEP_BASE_US * CLK_MHZ;
	localparam int FRAME_BITS       = 16;
	localparam logic [7:0] LFSR_SEED = 8'h01;
	// Step-time multiples of the 40 us base: 40,80,160,320,520,1040,2040,4040 us
	localparam logic [6:0] STEP_MULT [8] = '{7'h01, 7'h02, 7'h04, 7'h08,
		7'h0D, 7'h1A, 7'h33, 7'h65};
	// ==========================================================
	// Start-up sequence states
	typedef enum logic [2:0] {
		ST_OFF   = 3'b001,
		ST_START = 3'b010,
		ST_RUN   = 3'b100
	} bcdc_state_e;
endpackage

// File: bcdc_props.sv
// Port-level checker for the boost configuration block
`timescale 1ns/1ps
`default_nettype none
module bcdc_props
	import bcdc_pkg::*;
#(
	parameter int STARTUP_CYCLES = STARTUP_CYC,
	parameter int STEP_BASE      = STEP_BASE_CYC
) (
	input wire logic       CLOCK,
	input wire logic       NRST,
	input wire logic       SPI_CS_N,
	input wire logic       SENSE_AT_LIMIT1,
	input wire logic       GATE_DRV1,
	input wire logic       GATE_DRV2,
	input wire logic       SW_CYCLE1,
	input wire logic       SW_CYCLE2,
	input wire logic       SLOPE_COMP_ON1,
	input wire logic       SLOPE_COMP_ON2,
	input wire logic       GATE_SUPPLY_ON,
	input wire logic [1:0] DEAD_BAND,
	input wire logic       OUT2_RAMP_STEP
);
	// ==========================================================
	// Assertions
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!NRST);
	// Five samples cover the two-stage synchroniser plus the gate register
	a_limit_cuts_gate: assert property (SENSE_AT_LIMIT1 [*5] |-> !GATE_DRV1)
		else $error("gate 1 driven while current limit held");
	a_slope_with_gate1: assert property (GATE_DRV1 |-> SLOPE_COMP_ON1)
		else $error("slope compensation 1 off while gate 1 on");
	a_slope_with_gate2: assert property (GATE_DRV2 |-> SLOPE_COMP_ON2)
		else $error("slope compensation 2 off while gate 2 on");
	a_supply_before_gate: assert property ($rose(GATE_DRV1) |-> GATE_SUPPLY_ON)
		else $error("gate 1 started without gate supply");
	a_startup_gap: assert property ($rose(GATE_SUPPLY_ON) |-> (!(GATE_DRV1 || GATE_DRV2)) [*8])
		else $error("gate switched during start-up interval");
	a_cycle_min_len: assert property (SW_CYCLE1 |=> !SW_CYCLE1)
		else $error("switching cycle shorter than two clocks");
	a_cycle2_min_len: assert property (SW_CYCLE2 |=> !SW_CYCLE2)
		else $error("switching cycle 2 shorter than two clocks");
	a_band_commit: assert property (!$stable(DEAD_BAND) |-> SPI_CS_N && $past(SPI_CS_N, 3))
		else $error("dead band changed outside a completed write");
	a_ramp_spacing: assert property (OUT2_RAMP_STEP |=> (!OUT2_RAMP_STEP) [*3])
		else $error("ramp steps closer than the base interval");
	c_gate_on: cover property ($rose(GATE_DRV1));
	c_limit_cut: cover property ($fell(GATE_DRV1) && SENSE_AT_LIMIT1);
	c_ramp: cover property (OUT2_RAMP_STEP);
	c_band: cover property (!$stable(DEAD_BAND));
endmodule
bind bcdc_top bcdc_props #(.STARTUP_CYCLES(STARTUP_CYCLES), .STEP_BASE(STEP_BASE)) u_props (
	.CLOCK(CLOCK), .NRST(NRST), .SPI_CS_N(SPI_CS_N), .SENSE_AT_LIMIT1(SENSE_AT_LIMIT1),
	.GATE_DRV1(GATE_DRV1), .GATE_DRV2(GATE_DRV2), .SW_CYCLE1(SW_CYCLE1), .SW_CYCLE2(SW_CYCLE2),
	.SLOPE_COMP_ON1(SLOPE_COMP_ON1), .SLOPE_COMP_ON2(SLOPE_COMP_ON2),
	.GATE_SUPPLY_ON(GATE_SUPPLY_ON), .DEAD_BAND(DEAD_BAND), .OUT2_RAMP_STEP(OUT2_RAMP_STEP));
`default_nettype wire

// File: bcdc_top.sv
// Boost converter configuration registers, serial access and dither generators
// How it works
// - Dead-band code bits 5:4 select 180 mV, 350 mV, 700 mV or 1.4 V.
// - Dead-band register at 30h is written only in configuration mode.
// - Enabled dither varies a channel's switching divisor by triangle or random sequence.
// - Random offset range follows scenario and width codes, scaled per width.
// - Switching period equals nominal divisor plus signed dither offset.
// - 1Ch bits 0/2 enable dither per channel; bits 1/3 choose random profile.
// - 1Ch bit 5 set restarts conversion once temperature error clears.
// - 1Ch bit 4 set restarts conversion once supply error clears.
// - Triangle in scenario 00/01 sweeps 0 up to 255>>width and back.
// - Triangle in scenario 10 sweeps 0 down to -256>>width and back.
// - Triangle in scenario 11 sweeps -128..+127, halved per width code.
// - Scenario register: width 7:6, scenario 5:4, phase enables 3:0.
// - Current limit hit turns gate off until next switching cycle starts.
// - Slope compensation stays on while the current limit acts.
// - Output enable bits act only in operation mode.
// - Gate-drive supply turns on when either output is enabled.
// - Gates switch only after start-up interval and with gate supply good.
// - Function-control bit 6 makes supply measurement available before start.
// - Function-control bit 3 enables the chip-select low timer.
// - Function-control bit 0 selects configuration or locked operation mode.
`timescale 1ns/1ps
`default_nettype none
module bcdc_top
	import bcdc_pkg::*;
#(
	parameter int STARTUP_CYCLES = STARTUP_CYC,
	parameter int STEP_BASE      = STEP_BASE_CYC
) (
	input  wire logic        CLOCK,
	input  wire logic        NRST,
	input  wire logic        CE,
	input  wire logic        SPI_SCLK,
	input  wire logic        SPI_CS_N,
	input  wire logic        SPI_MOSI,
	output var  logic        SPI_MISO,
	output var  logic        SPI_MISO_OE_N,
	input  wire logic [11:0] NOM_DIV1,
	input  wire logic [11:0] NOM_DIV2,
	input  wire logic        SENSE_AT_LIMIT1,
	input  wire logic        SENSE_AT_LIMIT2,
	input  wire logic        GATE_SUPPLY_GOOD,
	input  wire logic        TEMP_ERR,
	input  wire logic        VBAT_ERR,
	output var  logic        GATE_DRV1,
	output var  logic        GATE_DRV2,
	output var  logic        SW_CYCLE1,
	output var  logic        SW_CYCLE2,
	output var  logic        SLOPE_COMP_ON1,
	output var  logic        SLOPE_COMP_ON2,
	output var  logic        GATE_SUPPLY_ON,
	output var  logic        VBAT_MEAS_ON,
	output var  logic        SELECT_LOW_TIMER_ON,
	output var  logic [1:0]  DEAD_BAND,
	output var  logic [7:0]  OUT1_PEAK_CURRENT_CODE,
	output var  logic [7:0]  OUT2_PEAK_CURRENT_CODE,
	output var  logic [3:0]  OUT1_PHASE_ON,
	output var  logic [3:0]  OUT2_PHASE_ON,
	output var  logic        OUT2_RAMP_STEP,
	output var  logic [1:0]  OUT2_STEP_SIZE
);
	// ==========================================================
	// Input synchronisers: stage one feeds stage two only
	logic [6:0] sync1_reg;
	logic [6:0] sync2_reg;
	logic       sclk_d_reg;
	logic       cs_d_reg;
	wire  [6:0] pins_in = {VBAT_ERR, TEMP_ERR, GATE_SUPPLY_GOOD, SENSE_AT_LIMIT2,
		SENSE_AT_LIMIT1, SPI_MOSI, SPI_SCLK};
	wire        cs_in   = SPI_CS_N;
	logic       cs1_reg;
	logic       cs2_reg;
	wire        sclk_s  = sync2_reg[0];
	wire        mosi_s  = sync2_reg[1];
	wire  [1:0] limit_s = sync2_reg[3:2];
	wire        good_s  = sync2_reg[4];
	wire        temp_s  = sync2_reg[5];
	wire        vbat_s  = sync2_reg[6];
	wire        sclk_rise = sclk_s & ~sclk_d_reg;
	wire        sclk_fall = ~sclk_s & sclk_d_reg;
	wire        cs_active = ~cs2_reg;
	wire        cs_end    = cs2_reg & ~cs_d_reg;

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			sync1_reg  <= 7'h00;
			sync2_reg  <= 7'h00;
			cs1_reg    <= 1'b1;
			cs2_reg    <= 1'b1;
			sclk_d_reg <= 1'b0;
			cs_d_reg   <= 1'b1;
		end else if (CE) begin
			sync1_reg  <= pins_in;
			sync2_reg  <= sync1_reg;
			cs1_reg    <= cs_in;
			cs2_reg    <= cs1_reg;
			sclk_d_reg <= sclk_s;
			cs_d_reg   <= cs2_reg;
		end
	end

	// ==========================================================
	// Serial frame: 7-bit address, read bit, 8 data bits, MSB first
	logic [15:0] rx_reg;
	logic [4:0]  bit_cnt_reg;
	logic [7:0]  tx_reg;
	logic [7:0]  func_reg;
	logic [7:0]  ilim1_reg;
	logic [7:0]  ilim2_reg;
	logic [7:0]  scen1_reg;
	logic [7:0]  scen2_reg;
	logic [7:0]  dith_reg;
	logic [7:0]  out2_ramp_disable_reg;
	logic [1:0]  db_reg;
	logic [7:0]  rdata;
	wire  [6:0]  rd_adr   = rx_reg[6:0];
	wire  [6:0]  wr_adr   = rx_reg[15:9];
	wire  [7:0]  wr_dat   = rx_reg[7:0];
	// Frames of the wrong length are discarded so a glitched clock cannot corrupt setup
	wire         wr_ok    = cs_end & (bit_cnt_reg == 5'(FRAME_BITS)) & ~rx_reg[8];
	wire         cfg_mode = ~func_reg[FC_CFG_DONE];
	wire         addr_cnt = bit_cnt_reg == 5'h07;

	always_comb begin
		unique case (rd_adr)
			ADR_FUNC_CTRL: rdata = func_reg;
			ADR_ILIM_OUT1: rdata = ilim1_reg;
			ADR_ILIM_OUT2: rdata = ilim2_reg;
			ADR_SCEN_OUT1: rdata = scen1_reg;
			ADR_SCEN_OUT2: rdata = scen2_reg;
			ADR_DITH_EN:   rdata = dith_reg;
			ADR_RAMP_OUT2: rdata = out2_ramp_disable_reg;
			ADR_DEAD_BAND: rdata = {2'b00, db_reg, DB_INTERNAL};
			default:       rdata = 8'h00;
		endcase
	end

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			rx_reg        <= 16'h0000;
			bit_cnt_reg   <= 5'h00;
			tx_reg        <= 8'h00;
			SPI_MISO      <= 1'b0;
			SPI_MISO_OE_N <= 1'b1;
		end else if (CE) begin
			SPI_MISO_OE_N <= ~cs_active;
			if (!cs_active) begin
				bit_cnt_reg <= 5'h00;
			end else if (sclk_rise) begin
				rx_reg <= {rx_reg[14:0], mosi_s};
				if (bit_cnt_reg != 5'h1F) begin
					bit_cnt_reg <= bit_cnt_reg + 5'h01;
				end
				if (addr_cnt) begin
					tx_reg <= rdata;
				end
			end else if (sclk_fall && bit_cnt_reg >= 5'h08) begin
				SPI_MISO <= tx_reg[7];
				tx_reg   <= {tx_reg[6:0], 1'b0};
			end
		end
	end

	// ==========================================================
	// Register file
	wire wr_func  = wr_ok & (wr_adr == ADR_FUNC_CTRL);
	wire wr_ilim1 = wr_ok & (wr_adr == ADR_ILIM_OUT1);
	wire wr_ilim2 = wr_ok & (wr_adr == ADR_ILIM_OUT2);
	wire wr_scen1 = wr_ok & (wr_adr == ADR_SCEN_OUT1);
	wire wr_scen2 = wr_ok & (wr_adr == ADR_SCEN_OUT2);
	wire wr_dith  = wr_ok & (wr_adr == ADR_DITH_EN);
	wire wr_out2_ramp_disable = wr_ok & (wr_adr == ADR_RAMP_OUT2);
	wire wr_db    = wr_ok & (wr_adr == ADR_DEAD_BAND) & cfg_mode;

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			func_reg  <= RST_FUNC_CTRL;
			ilim1_reg <= RST_ILIM;
			ilim2_reg <= RST_ILIM;
			scen1_reg <= RST_SCEN;
			scen2_reg <= RST_SCEN;
			dith_reg  <= RST_DITH_EN;
			out2_ramp_disable_reg <= RST_RAMP_OUT2;
			db_reg    <= RST_DEAD_BAND;
		end else if (CE) begin
			if (wr_func)  func_reg  <= wr_dat;
			if (wr_ilim1) ilim1_reg <= wr_dat;
			if (wr_ilim2) ilim2_reg <= wr_dat;
			if (wr_scen1) scen1_reg <= wr_dat;
			if (wr_scen2) scen2_reg <= wr_dat;
			if (wr_dith)  dith_reg  <= wr_dat;
			if (wr_out2_ramp_disable) out2_ramp_disable_reg <= wr_dat;
			if (wr_db)    db_reg    <= wr_dat[DB_LSB +: 2];
		end
	end

	// ==========================================================
	// Fault power-down with optional restart
	logic temp_off_reg;
	logic vbat_off_reg;
	wire  en_any  = cfg_mode ? 1'b0 : (func_reg[FC_OUT1_EN] | func_reg[FC_OUT2_EN]);
	// Without restart the latch holds until software drops both enables or selects configuration mode
	wire  temp_next = temp_s | (temp_off_reg & ~dith_reg[DE_RST_TEMP] & en_any);
	wire  vbat_next = vbat_s | (vbat_off_reg & ~dith_reg[DE_RST_VBAT] & en_any);
	wire  fault   = temp_off_reg | vbat_off_reg;
	wire  out1_on = ~cfg_mode & func_reg[FC_OUT1_EN] & ~fault;
	wire  out2_on = ~cfg_mode & func_reg[FC_OUT2_EN] & ~fault;

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			temp_off_reg <= 1'b0;
			vbat_off_reg <= 1'b0;
		end else if (CE) begin
			temp_off_reg <= temp_next;
			vbat_off_reg <= vbat_next;
		end
	end

	// ==========================================================
	// Start-up sequence
	bcdc_state_e state_reg;
	bcdc_state_e state_next;
	logic [31:0] start_cnt_reg;
	wire         start_done = start_cnt_reg >= 32'(STARTUP_CYCLES);
	wire         switching  = (state_reg == ST_RUN) & good_s;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_OFF:   if (out1_on | out2_on) state_next = ST_START;
			ST_START: begin
				if (!(out1_on | out2_on)) state_next = ST_OFF;
				else if (start_done && good_s) state_next = ST_RUN;
			end
			ST_RUN:   if (!(out1_on | out2_on)) state_next = ST_OFF;
			default:  state_next = ST_OFF;
		endcase
	end

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			state_reg     <= ST_OFF;
			start_cnt_reg <= 32'h0000_0000;
		end else if (CE) begin
			state_reg <= state_next;
			if (state_reg != ST_START) start_cnt_reg <= 32'h0000_0000;
			else if (!start_done) start_cnt_reg <= start_cnt_reg + 32'h0000_0001;
		end
	end

	// ==========================================================
	// Per-channel dither and switching cycle
	wire [1:0]  ch_dith = {dith_reg[DE_CH2_ON], dith_reg[DE_CH1_ON]};
	wire [1:0]  ch_rand = {dith_reg[DE_CH2_RAND], dith_reg[DE_CH1_RAND]};
	wire [7:0]  ch_scen [2];
	wire [11:0] ch_nom [2];
	wire [1:0]  ch_run = {out2_on & switching, out1_on & switching};
	logic [1:0] gate_reg;
	logic [1:0] cyc_reg;
	assign ch_scen[0] = scen1_reg;
	assign ch_scen[1] = scen2_reg;
	assign ch_nom[0]  = NOM_DIV1;
	assign ch_nom[1]  = NOM_DIV2;

	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		logic        [12:0] sw_cnt_reg;
		logic        [8:0]  tri_reg;
		logic               down_reg;
		logic        [7:0]  lfsr_reg;
		logic signed [9:0]  x_reg;
		wire  [1:0]  wid  = ch_scen[ch][SC_WIDTH_LSB +: 2];
		wire  [1:0]  scen = ch_scen[ch][SC_SCEN_LSB +: 2];
		wire  [8:0]  span = (scen == 2'b10) ? (9'h100 >> wid) : (9'h0FF >> wid);
		wire signed [9:0] tri_base = (scen == 2'b11) ? -$signed(10'(9'h080 >> wid)) :
			(scen == 2'b10) ? -$signed(10'(span)) : 10'sh000;
		wire signed [9:0] x_tri = tri_base + $signed({1'b0, tri_reg});
		wire        [7:0] r_pos = lfsr_reg >> wid;
		wire signed [9:0] r_sgn = $signed({{2{lfsr_reg[7]}}, lfsr_reg}) >>> wid;
		wire signed [9:0] x_rnd = (scen == 2'b11) ? r_sgn :
			(scen == 2'b10) ? -10'sh001 - $signed({3'b000, lfsr_reg[7:1] >> wid}) :
			$signed({2'b00, r_pos});
		wire signed [9:0] x_new = ~ch_dith[ch] ? 10'sh000 : (ch_rand[ch] ? x_rnd : x_tri);
		// Period is nominal plus offset; floor of two keeps a zero-length cycle out
		wire signed [13:0] div_raw = $signed({2'b00, ch_nom[ch]}) + 14'(x_reg);
		wire        [12:0] div_eff = (div_raw < 14'sd2) ? 13'h0002 : div_raw[12:0];
		wire               cyc_end = sw_cnt_reg >= div_eff - 13'h0001;
		wire         [8:0] tri_nxt = down_reg ? ((tri_reg == 9'h000) ? 9'h001 : tri_reg - 9'h001) :
			((tri_reg >= span) ? span - 9'h001 : tri_reg + 9'h001);

		always_ff @(posedge CLOCK or negedge NRST) begin
			if (!NRST) begin
				sw_cnt_reg   <= 13'h0000;
				tri_reg      <= 9'h000;
				down_reg     <= 1'b0;
				lfsr_reg     <= LFSR_SEED;
				x_reg        <= 10'sh000;
				gate_reg[ch] <= 1'b0;
				cyc_reg[ch]  <= 1'b0;
			end else if (CE) begin
				cyc_reg[ch] <= cyc_end & ch_run[ch];
				if (!ch_run[ch]) begin
					sw_cnt_reg   <= 13'h0000;
					gate_reg[ch] <= 1'b0;
				end else if (cyc_end) begin
					sw_cnt_reg   <= 13'h0000;
					gate_reg[ch] <= 1'b1;
					tri_reg      <= tri_nxt;
					if (tri_reg == 9'h000) down_reg <= 1'b0;
					else if (tri_reg >= span) down_reg <= 1'b1;
					lfsr_reg     <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^
						lfsr_reg[4] ^ lfsr_reg[3]};
					x_reg        <= x_new;
				end else begin
					sw_cnt_reg <= sw_cnt_reg + 13'h0001;
					if (limit_s[ch]) gate_reg[ch] <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// Output 2 ramp-up stepping
	logic [6:0]  step_mult_reg;
	logic [31:0] step_cnt_reg;
	wire  [6:0]  step_mult = STEP_MULT[out2_ramp_disable_reg[RU_TIME_LSB +: 3]];
	wire         ramp_run  = out2_on & switching & ~out2_ramp_disable_reg[RU_DISABLE];
	wire         base_end  = step_cnt_reg >= 32'(STEP_BASE) - 32'h0000_0001;

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			step_cnt_reg   <= 32'h0000_0000;
			step_mult_reg  <= 7'h00;
			OUT2_RAMP_STEP <= 1'b0;
		end else if (CE) begin
			OUT2_RAMP_STEP <= 1'b0;
			if (!ramp_run) begin
				step_cnt_reg  <= 32'h0000_0000;
				step_mult_reg <= 7'h00;
			end else if (base_end) begin
				step_cnt_reg <= 32'h0000_0000;
				if (step_mult_reg + 7'h01 >= step_mult) begin
					step_mult_reg  <= 7'h00;
					OUT2_RAMP_STEP <= 1'b1;
				end else begin
					step_mult_reg <= step_mult_reg + 7'h01;
				end
			end else begin
				step_cnt_reg <= step_cnt_reg + 32'h0000_0001;
			end
		end
	end

	// ==========================================================
	// Registered control outputs
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			GATE_DRV1              <= 1'b0;
			GATE_DRV2              <= 1'b0;
			SW_CYCLE1              <= 1'b0;
			SW_CYCLE2              <= 1'b0;
			SLOPE_COMP_ON1         <= 1'b0;
			SLOPE_COMP_ON2         <= 1'b0;
			GATE_SUPPLY_ON         <= 1'b0;
			VBAT_MEAS_ON           <= 1'b0;
			SELECT_LOW_TIMER_ON    <= 1'b0;
			DEAD_BAND              <= RST_DEAD_BAND;
			OUT1_PEAK_CURRENT_CODE <= RST_ILIM;
			OUT2_PEAK_CURRENT_CODE <= RST_ILIM;
			OUT1_PHASE_ON          <= 4'h0;
			OUT2_PHASE_ON          <= 4'h0;
			OUT2_STEP_SIZE         <= 2'h0;
		end else if (CE) begin
			// Gate drops with the channel so slope compensation never trails it
			GATE_DRV1              <= gate_reg[0] & ~limit_s[0] & ch_run[0];
			GATE_DRV2              <= gate_reg[1] & ~limit_s[1] & ch_run[1];
			SW_CYCLE1              <= cyc_reg[0];
			SW_CYCLE2              <= cyc_reg[1];
			// Kept on through limit events to avoid subharmonic oscillation
			SLOPE_COMP_ON1         <= ch_run[0];
			SLOPE_COMP_ON2         <= ch_run[1];
			GATE_SUPPLY_ON         <= state_next != ST_OFF;
			VBAT_MEAS_ON           <= func_reg[FC_VBAT_MEAS] | out1_on | out2_on;
			SELECT_LOW_TIMER_ON    <= func_reg[FC_SEL_TMR];
			DEAD_BAND              <= db_reg;
			OUT1_PEAK_CURRENT_CODE <= ilim1_reg;
			OUT2_PEAK_CURRENT_CODE <= ilim2_reg;
			OUT1_PHASE_ON          <= scen1_reg[3:0];
			OUT2_PHASE_ON          <= scen2_reg[3:0];
			OUT2_STEP_SIZE         <= out2_ramp_disable_reg[1:0];
		end
	end
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench for the boost configuration block
`timescale 1ns/1ps
`default_nettype none
module tb
	import bcdc_pkg::*;
;
	// ==========================================================
	// Stimulus, clock and instances
	logic       clock = 1'b0;
	logic       nrst, lim1, good, terr, verr, ce;
	wire logic  miso_oe_n;
	wire logic  sclk, cs_n, mosi, miso, g1, g2, swc1, slope1, gsup, vmeas, tmr, rstep;
	wire logic [1:0] dband, stsz;
	wire logic [7:0] pk1, pk2;
	wire logic [3:0] ph1, ph2;
	logic [7:0] rd;
	int         err_count = 0;
	int         n_tests = 0;
	always #2.5 clock = ~clock;
	// Short start-up and ramp base keep the run brief
	bcdc_top #(.STARTUP_CYCLES(20), .STEP_BASE(4)) dut (
		.CLOCK(clock), .NRST(nrst), .CE(ce), .SPI_SCLK(sclk), .SPI_CS_N(cs_n),
		.SPI_MOSI(mosi), .SPI_MISO(miso), .SPI_MISO_OE_N(miso_oe_n), .NOM_DIV1(12'h028),
		.NOM_DIV2(12'h028), .SENSE_AT_LIMIT1(lim1), .SENSE_AT_LIMIT2(1'b0),
		.GATE_SUPPLY_GOOD(good), .TEMP_ERR(terr), .VBAT_ERR(verr), .GATE_DRV1(g1),
		.GATE_DRV2(g2), .SW_CYCLE1(swc1), .SW_CYCLE2(), .SLOPE_COMP_ON1(slope1),
		.SLOPE_COMP_ON2(), .GATE_SUPPLY_ON(gsup), .VBAT_MEAS_ON(vmeas),
		.SELECT_LOW_TIMER_ON(tmr), .DEAD_BAND(dband), .OUT1_PEAK_CURRENT_CODE(pk1),
		.OUT2_PEAK_CURRENT_CODE(pk2), .OUT1_PHASE_ON(ph1), .OUT2_PHASE_ON(ph2),
		.OUT2_RAMP_STEP(rstep), .OUT2_STEP_SIZE(stsz));
	bcdc_host host (.CLOCK(clock), .SCLK(sclk), .CS_N(cs_n), .MOSI(mosi), .MISO(miso));
	// ==========================================================
	// Helpers
	task automatic finish_test();
		if (err_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("FAIL %s expected %0h seen %0h", what, exp, got);
			err_count++;
		end
	endtask
	task automatic rchk(input logic [6:0] a, input logic [7:0] e);
		host.rd(a, rd);
		chk("readback", 16'(e), 16'(rd));
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	// Clocks from one pulse to the next, of the ramp or the switching cycle
	task automatic gap(input bit r, output int n);
		int k;
		for (k = 0; k < 3000 && (r ? rstep : swc1) !== 1'b1; k++)
			tick(1);
		if (k == 3000) begin
			err_count++;
			finish_test();
		end
		n = 0;
		do begin
			tick(1);
			n++;
		end while ((r ? rstep : swc1) !== 1'b1 && n < 3000);
		if (n == 3000) begin
			err_count++;
			finish_test();
		end
	endtask
	task automatic hits(input int c, input bit r, output int n);
		n = 0;
		repeat (c) begin
			tick(1);
			if (r ? rstep === 1'b1 : (g1 === 1'b1 || g2 === 1'b1)) n++;
		end
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset();
		chk("supply", 16'h0000, 16'(gsup));
		chk("miso enable", 16'h0001, 16'(miso_oe_n));
		rchk(ADR_FUNC_CTRL, 8'h00);
		rchk(ADR_DITH_EN, 8'h00);
		rchk(ADR_DEAD_BAND, 8'h09);
		rchk(7'h7F, 8'h00);
	endtask
	task automatic t_func();
		host.wr(ADR_FUNC_CTRL, 8'h48);
		chk("meas", 16'h0001, 16'(vmeas));
		chk("timer", 16'h0001, 16'(tmr));
		host.wr(ADR_FUNC_CTRL, 8'h00);
		chk("timer off", 16'h0000, 16'(tmr));
		chk("meas off", 16'h0000, 16'(vmeas));
		// Frozen clock enable must swallow a whole frame
		ce <= 1'b0;
		host.wr(ADR_FUNC_CTRL, 8'h08);
		ce <= 1'b1;
		tick(4);
		chk("frozen write", 16'h0000, 16'(tmr));
	endtask
	task automatic t_dead();
		for (int c = 0; c < 4; c++) begin
			host.wr(ADR_DEAD_BAND, 8'(c * 16));
			chk("dead band", 16'(c), 16'(dband));
			rchk(ADR_DEAD_BAND, 8'(c * 16 + 9));
		end
		host.wr(ADR_FUNC_CTRL, 8'h01);
		host.wr(ADR_DEAD_BAND, 8'h10);
		chk("locked band", 16'h0003, 16'(dband));
		rchk(ADR_DEAD_BAND, 8'h39);
		host.wr(ADR_FUNC_CTRL, 8'h00);
	endtask
	task automatic t_regs();
		host.wr(ADR_ILIM_OUT1, 8'h80);
		host.wr(ADR_ILIM_OUT2, 8'h3C);
		host.wr(ADR_SCEN_OUT1, 8'hA5);
		host.wr(ADR_SCEN_OUT2, 8'h3A);
		chk("limit 1", 16'h0080, 16'(pk1));
		chk("limit 2", 16'h003C, 16'(pk2));
		chk("phases 1", 16'h0005, 16'(ph1));
		chk("phases 2", 16'h000A, 16'(ph2));
		rchk(ADR_SCEN_OUT2, 8'h3A);
		host.frame(15, 16'h0E22, rd);
		chk("short frame", 16'h0080, 16'(pk1));
	endtask
	task automatic t_enable();
		int n;
		host.wr(ADR_FUNC_CTRL, 8'h02);
		hits(60, 0, n);
		chk("config gate", 16'h0000, 16'(n));
		chk("config supply", 16'h0000, 16'(gsup));
		host.wr(ADR_FUNC_CTRL, 8'h03);
		chk("supply on", 16'h0001, 16'(gsup));
		hits(80, 0, n);
		chk("gate no good", 16'h0000, 16'(n));
		good <= 1'b1;
		repeat (2) gap(0, n);
		chk("period", 16'h0028, 16'(n));
	endtask
	task automatic t_dither(input logic [7:0] de, input logic [7:0] sc, input int lo,
		input int hi, input bit full);
		int n;
		int mn;
		int mx;
		host.wr(ADR_DITH_EN, de);
		host.wr(ADR_SCEN_OUT1, sc);
		repeat (4) gap(0, n);
		mn = 9999;
		mx = 0;
		repeat (70) begin
			gap(0, n);
			if (n < mn) mn = n;
			if (n > mx) mx = n;
		end
		if (full) begin
			chk("sweep low", 16'(lo), 16'(mn));
			chk("sweep high", 16'(hi), 16'(mx));
		end else
			chk("random bounds", 16'h0001, 16'(mn >= lo && mx <= hi));
	endtask
	task automatic t_limit();
		int n;
		host.wr(ADR_DITH_EN, 8'h00);
		repeat (2) gap(0, n);
		tick(5);
		lim1 <= 1'b1;
		tick(8);
		lim1 <= 1'b0;
		chk("limit gate", 16'h0000, 16'(g1));
		chk("slope on", 16'h0001, 16'(slope1));
		tick(10);
		chk("gate held off", 16'h0000, 16'(g1));
		gap(0, n);
		tick(4);
		chk("gate back", 16'h0001, 16'(g1));
	endtask
	task automatic t_ramp();
		int n;
		host.wr(ADR_FUNC_CTRL, 8'h07);
		host.wr(ADR_RAMP_OUT2, 8'h09);
		chk("step size", 16'h0001, 16'(stsz));
		gap(1, n);
		chk("ramp gap", 16'h0010, 16'(n));
		host.wr(ADR_RAMP_OUT2, 8'h29);
		hits(100, 1, n);
		chk("ramp off", 16'h0000, 16'(n));
	endtask
	// A latched fault is cleared by dropping both enables before the next case
	task automatic t_fault(input logic [7:0] de, input bit temp, input bit back);
		int n;
		host.wr(ADR_DITH_EN, de);
		if (temp) terr <= 1'b1;
		else verr <= 1'b1;
		tick(6);
		hits(100, 0, n);
		chk("fault off", 16'h0000, 16'(n));
		terr <= 1'b0;
		verr <= 1'b0;
		hits(300, 0, n);
		chk("restart", 16'(back), 16'(n > 0));
		host.wr(ADR_FUNC_CTRL, 8'h00);
		host.wr(ADR_FUNC_CTRL, 8'h07);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		nrst = 1'b0;
		lim1 = 1'b0;
		good = 1'b0;
		terr = 1'b0;
		verr = 1'b0;
		ce = 1'b1;
		tick(20);
		nrst <= 1'b1;
		tick(4);
		t_reset();
		t_func();
		t_dead();
		t_regs();
		t_enable();
		t_dither(8'h01, 8'hC1, 40, 71, 1'b1);
		t_dither(8'h01, 8'hD1, 40, 71, 1'b1);
		t_dither(8'h01, 8'hE1, 8, 40, 1'b1);
		t_dither(8'h01, 8'hF1, 24, 55, 1'b1);
		t_dither(8'h03, 8'hC1, 40, 71, 1'b0);
		t_dither(8'h03, 8'hE1, 24, 39, 1'b0);
		t_dither(8'h03, 8'hF1, 24, 55, 1'b0);
		t_limit();
		t_ramp();
		t_fault(8'h20, 1'b1, 1'b1);
		t_fault(8'h00, 1'b1, 1'b0);
		t_fault(8'h10, 1'b0, 1'b1);
		t_fault(8'h00, 1'b0, 1'b0);
		finish_test();
	end
endmodule
`default_nettype wire
